// file: common/kpd_pkg.sv
// constants and types of the keypad scan and display refresh block
package kpd_pkg;
   // ==========================================================
   // register map
   localparam logic [4:0] ADR_CFG = 5'h00;
   localparam logic [4:0] ADR_STAT = 5'h04;
   localparam logic [4:0] ADR_FIFO = 5'h08;
   localparam logic [4:0] ADR_DISP = 5'h0c;
   localparam logic [4:0] ADR_CMD = 5'h10;
   // ==========================================================
   // field positions
   localparam int STAT_UND = 4;
   localparam int STAT_OVR = 5;
   localparam int STAT_SE = 6;
   localparam int CMD_CLR_FIFO = 0;
   localparam int CMD_CLR_DISP = 1;
   localparam int CMD_RST_SCAN = 2;
   // ==========================================================
   // timing and sizes
   localparam logic [4:0] PRESC_MIN = 5'h02;
   localparam logic [1:0] DEB_SCANS = 2'h2;
   localparam logic [3:0] FIFO_DEPTH = 4'h8;
   localparam logic [3:0] ERR_LIMIT = 4'h2;
   // ==========================================================
   // types
   typedef enum logic [1:0] {KM_LOCK = 2'h0, KM_ROLL = 2'h1, KM_SENS = 2'h2, KM_STRB = 2'h3} kpd_kind_t;
   typedef struct packed {
      logic blank_b;
      logic blank_a;
      logic err_en;
      logic [4:0] presc;
      logic right;
      logic disp16;
      kpd_kind_t kind;
      logic decoded;
   } kpd_cfg_t;
   localparam logic [12:0] CFG_RST = 13'h03e0;
endpackage

// file: rtl/kpd_scan.sv
// keypad scan, key fifo and display refresh with a wishbone register port
module kpd_scan
   import kpd_pkg::*;
#(
   parameter int SCAN_TICKS = 8
)(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [7:0] return_sense_lines_i,
   input wire logic shift_n_i,
   input wire logic control_strobe_input_i,
   output logic [3:0] scan_timing_lines_o,
   output logic [3:0] display_group_a_o,
   output logic [3:0] display_group_b_o,
   output logic display_blank_n_o,
   output logic irq_o
);
   // ==========================================================
   // helpers
   function automatic logic [3:0] ones(input logic [7:0] v);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 8; i++)
      begin
         n = n + {3'h0, v[i]};
      end
      return n;
   endfunction

   function automatic logic [2:0] lowest(input logic [7:0] v);
      logic [2:0] c;
      c = 3'h0;
      for (int i = 7; i >= 0; i--)
      begin
         if (v[i])
         begin
            c = 3'(i);
         end
      end
      return c;
   endfunction

   localparam int PW = (SCAN_TICKS > 1) ? $clog2(SCAN_TICKS) : 1;

   if (SCAN_TICKS < 1 || SCAN_TICKS > 256)
   begin : g_chk
      $error("SCAN_TICKS out of range");
   end

   // ==========================================================
   // state
   kpd_cfg_t cfg_ff, nxt_cfg;
   logic ack_ff, nxt_ack;
   logic [31:0] rdat_ff, nxt_rdat;
   logic [4:0] div_ff, nxt_div;
   logic [PW-1:0] pos_ff, nxt_pos;
   logic [3:0] cnt_ff, nxt_cnt;
   logic [3:0] scan_ff, nxt_scan;
   logic busy_ff, nxt_busy;
   logic [5:0] key_ff, nxt_key;
   logic [1:0] dcnt_ff, nxt_dcnt;
   logic [3:0] ecnt_ff, nxt_ecnt;
   logic [2:0] wp_ff, nxt_wp;
   logic [2:0] rp_ff, nxt_rp;
   logic [3:0] num_ff, nxt_num;
   logic und_ff, nxt_und;
   logic ovr_ff, nxt_ovr;
   logic se_ff, nxt_se;
   logic ev_ff, nxt_ev;
   logic pend_ff, nxt_pend;
   logic strb_ff, nxt_strb;
   logic irq_ff, nxt_irq;
   logic [3:0] dwp_ff, nxt_dwp;
   logic [3:0] a_ff, nxt_a;
   logic [3:0] b_ff, nxt_b;
   logic bn_ff, nxt_bn;
   logic [7:0] fifo_mem [8];
   logic [7:0] img_mem [8];
   logic [7:0] dram [16];

   logic req, wr, rd, tick, sample, fifo_we, img_we, dram_we, dram_clr;
   logic [4:0] presc_eff;
   logic [2:0] row, fifo_wa;
   logic [7:0] closed, newc, fifo_wd, img_wd;
   logic [3:0] dmask, didx;
   logic [15:0] wmask;

   // ==========================================================
   // bus, configuration and scan timing
   always_comb
   begin
      req = wb_cyc_i & wb_stb_i & ~ack_ff;
      wr = req & wb_we_i;
      rd = req & ~wb_we_i;
      wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
      nxt_ack = req;
      nxt_cfg = cfg_ff;
      if (wr && wb_adr_i == ADR_CFG)
      begin
         nxt_cfg = kpd_cfg_t'(13'((16'(cfg_ff) & ~wmask | wb_dat_i[15:0] & wmask) & 16'h1fff));
      end
      nxt_rdat = 32'h0000_0000;
      if (rd)
      begin
         unique case (wb_adr_i)
            ADR_CFG: nxt_rdat = {19'h0, cfg_ff};
            ADR_STAT: nxt_rdat = {24'h0, 1'b0, se_ff, ovr_ff, und_ff, num_ff};
            ADR_FIFO: nxt_rdat = {24'h0, fifo_mem[rp_ff]};
            default: nxt_rdat = 32'h0000_0000;
         endcase
      end
      presc_eff = (cfg_ff.presc < PRESC_MIN) ? PRESC_MIN : cfg_ff.presc;
      tick = (div_ff >= presc_eff - 5'h01);
      nxt_div = tick ? 5'h00 : div_ff + 5'h01;
      sample = tick && (pos_ff == PW'(SCAN_TICKS - 1));
      nxt_pos = pos_ff;
      if (tick)
      begin
         nxt_pos = sample ? '0 : pos_ff + PW'(1);
      end
      nxt_cnt = sample ? cnt_ff + 4'h1 : cnt_ff;
      if (wr && wb_adr_i == ADR_CMD && wb_sel_i[0] && wb_dat_i[CMD_RST_SCAN])
      begin
         nxt_cnt = 4'h0;
         nxt_pos = '0;
      end
      if (cfg_ff.decoded)
      begin
         nxt_scan = 4'h1 << nxt_cnt[1:0];
      end
      else
      begin
         nxt_scan = nxt_cnt;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cfg_ff <= kpd_cfg_t'(CFG_RST);
         ack_ff <= 1'b0;
         rdat_ff <= 32'h0000_0000;
         div_ff <= 5'h00;
         pos_ff <= '0;
         cnt_ff <= 4'h0;
         scan_ff <= 4'h0;
      end
      else
      begin
         cfg_ff <= nxt_cfg;
         ack_ff <= nxt_ack;
         rdat_ff <= nxt_rdat;
         div_ff <= nxt_div;
         pos_ff <= nxt_pos;
         cnt_ff <= nxt_cnt;
         scan_ff <= nxt_scan;
      end
   end

   // ==========================================================
   // key debounce, sensor image, strobe entry and fifo
   always_comb
   begin
      row = cnt_ff[2:0];
      closed = ~return_sense_lines_i;
      newc = closed & ~img_mem[row];
      img_wd = closed;
      img_we = 1'b0;
      fifo_we = 1'b0;
      fifo_wa = wp_ff;
      fifo_wd = 8'h00;
      nxt_busy = busy_ff;
      nxt_key = key_ff;
      nxt_dcnt = dcnt_ff;
      nxt_ecnt = ecnt_ff;
      nxt_se = se_ff;
      nxt_pend = pend_ff;
      nxt_strb = control_strobe_input_i;
      nxt_wp = wp_ff;
      nxt_rp = rp_ff;
      nxt_num = num_ff;
      nxt_und = und_ff;
      nxt_ovr = ovr_ff;
      nxt_ev = ev_ff;
      // only the low 32 keys exist in decoded scan
      if (sample && !(cfg_ff.decoded && row[2]))
      begin
         unique case (cfg_ff.kind)
            KM_LOCK, KM_ROLL:
            begin
               img_we = 1'b1;
               // count each other closure once, in the first pass of the debounce
               if (busy_ff && dcnt_ff == 2'h0 && row != key_ff[5:3])
               begin
                  nxt_ecnt = (ecnt_ff > 4'h8) ? ecnt_ff : ecnt_ff + ones(newc);
               end
               if (newc != 8'h00 && (cfg_ff.kind == KM_LOCK || !busy_ff))
               begin
                  nxt_busy = !(cfg_ff.kind == KM_LOCK && ones(newc) > 4'h1);
                  nxt_key = {row, lowest(newc)};
                  nxt_dcnt = 2'h0;
                  nxt_ecnt = ones(newc);
               end
               else if (busy_ff && row == key_ff[5:3])
               begin
                  if (dcnt_ff == DEB_SCANS - 2'h1)
                  begin
                     nxt_busy = 1'b0;
                     if (closed[key_ff[2:0]])
                     begin
                        fifo_we = 1'b1;
                        fifo_wd = {~control_strobe_input_i, ~shift_n_i, key_ff};
                     end
                  end
                  else
                  begin
                     nxt_dcnt = dcnt_ff + 2'h1;
                  end
               end
               // keys not taken stay unseen so they start their own debounce later
               if (cfg_ff.kind == KM_ROLL)
               begin
                  img_wd = closed & ~newc | (busy_ff ? 8'h00 : newc & (8'h01 << lowest(newc)));
               end
               if (cfg_ff.kind == KM_ROLL && cfg_ff.err_en && nxt_ecnt > ERR_LIMIT)
               begin
                  nxt_se = 1'b1;
                  nxt_ev = 1'b1;
               end
            end
            KM_SENS:
            begin
               fifo_we = 1'b1;
               fifo_wa = row;
               fifo_wd = return_sense_lines_i;
               if (row == 3'h0 && pend_ff)
               begin
                  nxt_ev = 1'b1;
                  nxt_pend = 1'b0;
               end
               if (fifo_mem[row] != return_sense_lines_i)
               begin
                  nxt_pend = 1'b1;
               end
               if (!cfg_ff.err_en && closed != 8'h00)
               begin
                  nxt_se = 1'b1;
               end
            end
            default:
            begin
               img_we = 1'b0;
            end
         endcase
      end
      if (cfg_ff.kind == KM_STRB && control_strobe_input_i && !strb_ff)
      begin
         fifo_we = 1'b1;
         fifo_wd = return_sense_lines_i;
      end
      if (cfg_ff.kind != KM_SENS && fifo_we)
      begin
         if (num_ff == FIFO_DEPTH)
         begin
            fifo_we = 1'b0;
            nxt_ovr = 1'b1;
         end
         else
         begin
            nxt_wp = wp_ff + 3'h1;
            nxt_num = nxt_num + 4'h1;
         end
      end
      if (rd && wb_adr_i == ADR_FIFO)
      begin
         nxt_rp = rp_ff + 3'h1;
         if (cfg_ff.kind == KM_SENS)
         begin
            nxt_ev = nxt_ev & ~ev_ff; // set in this cycle survives the read
         end
         else if (num_ff == 4'h0)
         begin
            nxt_und = 1'b1;
            nxt_rp = rp_ff;
         end
         else
         begin
            nxt_num = nxt_num - 4'h1;
         end
      end
      if (wr && wb_adr_i == ADR_CMD && wb_sel_i[0] && wb_dat_i[CMD_CLR_FIFO])
      begin
         nxt_busy = 1'b0;
         nxt_wp = 3'h0;
         nxt_rp = 3'h0;
         nxt_num = 4'h0;
         // a flag set in this cycle survives the clear
         nxt_und = nxt_und & ~und_ff;
         nxt_ovr = nxt_ovr & ~ovr_ff;
         nxt_se = nxt_se & ~se_ff;
         nxt_ev = nxt_ev & ~ev_ff;
         nxt_pend = 1'b0;
      end
      nxt_irq = nxt_ev | (cfg_ff.kind != KM_SENS && nxt_num != 4'h0);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         busy_ff <= 1'b0;
         key_ff <= 6'h00;
         dcnt_ff <= 2'h0;
         ecnt_ff <= 4'h0;
         wp_ff <= 3'h0;
         rp_ff <= 3'h0;
         num_ff <= 4'h0;
         und_ff <= 1'b0;
         ovr_ff <= 1'b0;
         se_ff <= 1'b0;
         ev_ff <= 1'b0;
         pend_ff <= 1'b0;
         strb_ff <= 1'b1;
         irq_ff <= 1'b0;
      end
      else
      begin
         busy_ff <= nxt_busy;
         key_ff <= nxt_key;
         dcnt_ff <= nxt_dcnt;
         ecnt_ff <= nxt_ecnt;
         wp_ff <= nxt_wp;
         rp_ff <= nxt_rp;
         num_ff <= nxt_num;
         und_ff <= nxt_und;
         ovr_ff <= nxt_ovr;
         se_ff <= nxt_se;
         ev_ff <= nxt_ev;
         pend_ff <= nxt_pend;
         strb_ff <= nxt_strb;
         irq_ff <= nxt_irq;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < 8; i++)
         begin
            img_mem[i] <= 8'h00;
            fifo_mem[i] <= 8'h00;
         end
      end
      else
      begin
         if (img_we)
         begin
            img_mem[row] <= img_wd;
         end
         if (fifo_we)
         begin
            fifo_mem[fifo_wa] <= fifo_wd;
         end
      end
   end

   // ==========================================================
   // display memory and refresh
   always_comb
   begin
      dmask = cfg_ff.disp16 ? 4'hf : 4'h7;
      dram_we = wr && wb_adr_i == ADR_DISP && wb_sel_i[0];
      dram_clr = wr && wb_adr_i == ADR_CMD && wb_sel_i[0] && wb_dat_i[CMD_CLR_DISP];
      nxt_dwp = dwp_ff & dmask;
      if (dram_we)
      begin
         nxt_dwp = (dwp_ff + 4'h1) & dmask;
      end
      if (dram_clr)
      begin
         nxt_dwp = 4'h0;
      end
      // right entry rotates the view so the newest byte sits rightmost
      didx = cfg_ff.right ? ((cnt_ff + dwp_ff) & dmask) : (cnt_ff & dmask);
      nxt_a = cfg_ff.blank_a ? 4'h0 : dram[didx][7:4];
      nxt_b = cfg_ff.blank_b ? 4'h0 : dram[didx][3:0];
      nxt_bn = ~(cfg_ff.blank_a & cfg_ff.blank_b);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         dwp_ff <= 4'h0;
         a_ff <= 4'h0;
         b_ff <= 4'h0;
         bn_ff <= 1'b1;
      end
      else
      begin
         dwp_ff <= nxt_dwp;
         a_ff <= nxt_a;
         b_ff <= nxt_b;
         bn_ff <= nxt_bn;
      end
   end

   // no reset term: contents survive reset until cleared
   always_ff @(posedge clk_i)
   begin
      if (dram_clr)
      begin
         for (int i = 0; i < 16; i++)
         begin
            dram[i] <= 8'h00;
         end
      end
      else if (dram_we)
      begin
         dram[dwp_ff & dmask] <= wb_dat_i[7:0];
      end
   end

   // ==========================================================
   // outputs
   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdat_ff;
   assign scan_timing_lines_o = scan_ff;
   assign display_group_a_o = a_ff;
   assign display_group_b_o = b_ff;
   assign display_blank_n_o = bn_ff;
   assign irq_o = irq_ff;
endmodule // kpd_scan

// file: dv/kpd_scan_monitor.sv
// assertion checker for the keypad scan block
module kpd_scan_monitor
   import kpd_pkg::*;
#(
   parameter int SCAN_TICKS = 8
)(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [7:0] return_sense_lines_i,
   input wire logic shift_n_i,
   input wire logic control_strobe_input_i,
   input wire logic [3:0] scan_timing_lines_o,
   input wire logic [3:0] display_group_a_o,
   input wire logic [3:0] display_group_b_o,
   input wire logic display_blank_n_o,
   input wire logic irq_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ========
   // shadow configuration and scan spacing
   kpd_cfg_t cfg_ff, nxt_cfg;
   logic [3:0] scan_ff;
   logic [15:0] gap_ff, nxt_gap;
   logic [1:0] ok_ff, nxt_ok;
   logic wr, chg;
   logic [4:0] eff;
   always_comb
   begin
      wr = wb_ack_o && wb_we_i;
      chg = scan_timing_lines_o != scan_ff;
      eff = (cfg_ff.presc < PRESC_MIN) ? PRESC_MIN : cfg_ff.presc;
      nxt_cfg = (wr && wb_adr_i == ADR_CFG) ? kpd_cfg_t'(wb_dat_i[12:0]) : cfg_ff;
      nxt_gap = chg ? 16'h0001 : gap_ff + 16'h0001;
      nxt_ok = (chg && ok_ff != 2'h2) ? ok_ff + 2'h1 : ok_ff;
      if (wr)
         nxt_ok = 2'h0;
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cfg_ff <= kpd_cfg_t'(CFG_RST);
         scan_ff <= 4'h0;
         gap_ff <= 16'h0000;
         ok_ff <= 2'h0;
      end
      else
      begin
         cfg_ff <= nxt_cfg;
         scan_ff <= scan_timing_lines_o;
         gap_ff <= nxt_gap;
         ok_ff <= nxt_ok;
      end
   end
   // ========
   // properties
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   property p_ack_resp;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_resp: assert property (p_ack_resp) else $error("request not acknowledged");
   property p_unmapped;
      wb_ack_o && !wb_we_i && wb_adr_i > ADR_CMD |-> wb_dat_o == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_dec_scan;
      cfg_ff.decoded && chg && ok_ff != 2'h0 |->
         $onehot(scan_timing_lines_o) && scan_timing_lines_o == {scan_ff[2:0], scan_ff[3]};
   endproperty
   a_dec_scan: assert property (p_dec_scan) else $error("decoded scan not one-hot rotation");
   property p_enc_scan;
      !cfg_ff.decoded && chg && ok_ff != 2'h0 |-> scan_timing_lines_o == scan_ff + 4'h1;
   endproperty
   a_enc_scan: assert property (p_enc_scan) else $error("encoded scan not binary count");
   property p_scan_gap;
      chg && ok_ff == 2'h2 |-> gap_ff == 16'(SCAN_TICKS * int'(eff));
   endproperty
   a_scan_gap: assert property (p_scan_gap) else $error("scan position length wrong");
   property p_blank;
      cfg_ff.blank_a && cfg_ff.blank_b && ok_ff != 2'h0 |->
         !display_blank_n_o && display_group_a_o == 4'h0 && display_group_b_o == 4'h0;
   endproperty
   a_blank: assert property (p_blank) else $error("blank output not low");
   property p_strobe_irq;
      cfg_ff.kind == KM_STRB && ok_ff != 2'h0 && $rose(control_strobe_input_i) |-> ##[1:3] irq_o;
   endproperty
   a_strobe_irq: assert property (p_strobe_irq) else $error("strobe entry gave no interrupt");
endmodule // kpd_scan_monitor

bind kpd_scan kpd_scan_monitor #(.SCAN_TICKS(SCAN_TICKS)) mon (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i,
   .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .return_sense_lines_i, .shift_n_i,
   .control_strobe_input_i, .scan_timing_lines_o, .display_group_a_o, .display_group_b_o,
   .display_blank_n_o, .irq_o);

// file: dv/kpd_matrix.sv
// key switch matrix behind an external row decoder
module kpd_matrix
(
   input wire logic [3:0] scan_i,
   input wire logic [63:0] keys_i,
   output logic [7:0] return_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // open switches leave the column at the pull-up level
   assign return_o = ~keys_i[{scan_i[2:0], 3'h0} +: 8];
endmodule // kpd_matrix

// file: dv/kpd_scan_tb.sv
// self-checking testbench for the keypad scan block
module kpd_scan_tb
   import kpd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i;
   logic rst_i = 1'b1;
   logic [4:0] adr = 5'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat, dat_o;
   logic we = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic sh_n = 1'b1;
   logic ctl_n = 1'b1;
   logic strb_on = 1'b0;
   logic [7:0] strb_dat = 8'hff;
   logic [7:0] mat, ret;
   logic [63:0] keys = 64'h0;
   logic [3:0] scan, ga, gb;
   logic ack, blank_n, irq;
   logic [2:0] r, c;
   logic [7:0] d[9];
   int errors = 0;
   int checked = 0;
   int ticks = 0;
   int hits;
   assign ret = strb_on ? strb_dat : mat;
   initial
   begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   kpd_scan #(.SCAN_TICKS(2)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
      .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .return_sense_lines_i(ret), .shift_n_i(sh_n), .control_strobe_input_i(ctl_n),
      .scan_timing_lines_o(scan), .display_group_a_o(ga), .display_group_b_o(gb),
      .display_blank_n_o(blank_n), .irq_o(irq));
   kpd_matrix pm (.scan_i(scan), .keys_i(keys), .return_o(mat));
   // ========
   // helpers
   function automatic logic [31:0] cfgv(kpd_kind_t k, logic dec, logic [4:0] p, logic e, logic [1:0] bl);
      return {19'h0, bl, e, p, 2'b00, k, dec};
   endfunction
   function automatic logic [31:0] ent(logic [2:0] rr, logic [2:0] cc);
      return {24'h0, ~ctl_n, ~sh_n, rr, cc};
   endfunction
   task automatic chk(logic [31:0] g, logic [31:0] e);
      checked++;
      if (g !== e)
      begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wb(logic [4:0] a, logic w, logic [31:0] v);
      @(posedge clk_i);
      adr <= a;
      we <= w;
      wdat <= v;
      cyc <= 1'b1;
      stb <= 1'b1;
      do
         @(posedge clk_i);
      while (ack !== 1'b1);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wt(int n);
      repeat (n) @(posedge clk_i);
      @(negedge clk_i);
   endtask
   task automatic summarize();
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge clk_i)
   begin
      ticks++;
      if (ticks == 10000)
      begin
         errors++;
         summarize();
      end
   end
   // ========
   // scenarios
   initial
   begin
      void'($urandom(87));
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(ADR_CFG, 1'b0, 32'h0);
      chk(rdat, {19'h0, CFG_RST});
      wb(5'h14, 1'b0, 32'h0);
      chk(rdat, 32'h0);
      wb(ADR_CFG, 1'b1, cfgv(KM_LOCK, 1'b0, 5'h00, 1'b0, 2'b00));
      r = 3'($urandom);
      c = 3'($urandom);
      sh_n <= 1'($urandom);
      ctl_n <= 1'($urandom);
      keys <= 64'h1 << {r, c};
      wt(200);
      chk(irq, 1'b1);
      wb(ADR_STAT, 1'b0, 32'h0);
      chk(rdat, 32'h1);
      wb(ADR_FIFO, 1'b0, 32'h0);
      chk(rdat, ent(r, c));
      keys <= 64'h0;
      wt(100);
      @(posedge clk_i);
      keys <= (64'h1 << {r, c}) | (64'h1 << {r, ~c});
      wt(300);
      wb(ADR_STAT, 1'b0, 32'h0);
      chk(rdat, 32'h0);
      keys <= 64'h0;
      wt(100);
      wb(ADR_CMD, 1'b1, 32'h1);
      wb(ADR_CFG, 1'b1, cfgv(KM_ROLL, 1'b0, 5'h02, 1'b0, 2'b00));
      keys <= 64'h1 << {r, c};
      wt(40);
      @(posedge clk_i);
      keys <= keys | (64'h1 << {~r, c});
      wt(250);
      wb(ADR_STAT, 1'b0, 32'h0);
      chk(rdat, 32'h2);
      wb(ADR_FIFO, 1'b0, 32'h0);
      chk(rdat, ent(r, c));
      wb(ADR_FIFO, 1'b0, 32'h0);
      chk(rdat, ent(~r, c));
      keys <= 64'h0;
      wt(100);
      wb(ADR_CMD, 1'b1, 32'h1);
      wb(ADR_CFG, 1'b1, cfgv(KM_ROLL, 1'b0, 5'h02, 1'b1, 2'b00));
      keys <= 64'h0000_0000_0001_0101;
      wt(150);
      chk(irq, 1'b1);
      wb(ADR_STAT, 1'b0, 32'h0);
      chk(rdat[STAT_SE], 1'b1);
      keys <= 64'h0;
      wt(100);
      wb(ADR_CMD, 1'b1, 32'h1);
      wb(ADR_CFG, 1'b1, cfgv(KM_SENS, 1'b0, 5'h02, 1'b0, 2'b00));
      keys <= 64'h1 << {r, c};
      wt(100);
      chk(irq, 1'b1);
      wb(ADR_STAT, 1'b0, 32'h0);
      chk(rdat[STAT_SE], 1'b1);
      hits = 0;
      repeat (8)
      begin
         wb(ADR_FIFO, 1'b0, 32'h0);
         hits += (rdat[7:0] === ~(8'h01 << c)) ? 16 : ((rdat[7:0] === 8'hff) ? 1 : 0);
      end
      chk(hits, 32'h17);
      wt(100);
      chk(irq, 1'b0);
      wb(ADR_CMD, 1'b1, 32'h1);
      wb(ADR_CFG, 1'b1, cfgv(KM_STRB, 1'b1, 5'h02, 1'b0, 2'b00));
      strb_on <= 1'b1;
      ctl_n <= 1'b0;
      for (int i = 0; i < 3; i++)
      begin
         @(posedge clk_i);
         d[i] = 8'($urandom);
         strb_dat <= d[i];
         repeat (2) @(posedge clk_i);
         ctl_n <= 1'b1;
         repeat (2) @(posedge clk_i);
         ctl_n <= 1'b0;
      end
      wt(2);
      chk(irq, 1'b1);
      wb(ADR_STAT, 1'b0, 32'h0);
      chk(rdat, 32'h3);
      for (int i = 0; i < 3; i++)
      begin
         wb(ADR_FIFO, 1'b0, 32'h0);
         chk(rdat, {24'h0, d[i]});
      end
      wt(3);
      chk(irq, 1'b0);
      strb_on <= 1'b0;
      wb(ADR_CFG, 1'b1, cfgv(KM_LOCK, 1'b0, 5'h02, 1'b0, 2'b00));
      wb(ADR_CMD, 1'b1, 32'h2);
      for (int i = 0; i < 9; i++)
      begin
         d[i] = 8'($urandom);
         wb(ADR_DISP, 1'b1, {24'h0, d[i]});
      end
      d[0] = d[8];
      for (int i = 0; i < 8; i++)
      begin
         do
            @(negedge clk_i);
         while (scan[2:0] !== 3'(i));
         @(negedge clk_i);
         chk({ga, gb}, d[i]);
      end
      wb(ADR_CFG, 1'b1, cfgv(KM_LOCK, 1'b0, 5'h02, 1'b0, 2'b00) | 32'h10);
      wb(ADR_CMD, 1'b1, 32'h2);
      wb(ADR_DISP, 1'b1, {24'h0, d[1]});
      wb(ADR_DISP, 1'b1, {24'h0, d[2]});
      for (int i = 5; i < 8; i++)
      begin
         do
            @(negedge clk_i);
         while (scan[2:0] !== 3'(i));
         @(negedge clk_i);
         chk({ga, gb}, (i == 5) ? 32'h0 : {24'h0, d[i - 5]});
      end
      wb(ADR_CFG, 1'b1, cfgv(KM_LOCK, 1'b0, 5'h02, 1'b0, 2'b11));
      wt(20);
      chk({blank_n, ga, gb}, 32'h0);
      summarize();
   end
endmodule // kpd_scan_tb
